// ### hdl/standby_defs.svh
`ifndef STANDBY_DEFS_SVH
`define STANDBY_DEFS_SVH
// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_PORT_OUT 12'h008
`define OFS_IRQ_MASK 12'h00C
`define OFS_IRQ_REQ 12'h010
// Control register fields
`define CTRL_WD_STBY 0
`define CTRL_WD_ENABLE 4
`define CTRL_IT_CLKSEL 8
`define CTRL_IE 12
`define CTRL_CMP_FILTER 16
// Reset values
`define CTRL_RESET 32'h0000_0000
`define MASK_RESET 32'h0000_FFFF
`define PORT_RESET 32'h0000_0000
// Wake wait counts, in CPU clocks
`define HALT_WAIT_VEC 28
`define HALT_WAIT_NOVEC 20
`define STOP_WAIT_VEC 11
`define STOP_WAIT_NOVEC 3
// Clock supply stop after STOP release
`define STOP_HOLD_NS 27000
`define MCLK_PERIOD_NS 50
`define STOP_HOLD_CYC ((`STOP_HOLD_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`endif

// ### hdl/standby_pkg.sv
`default_nettype none
package standby_pkg;
  typedef enum logic [4:0] {
    st_run = 5'b00001,
    st_halt = 5'b00010,
    st_stop = 5'b00100,
    st_hold = 5'b01000,
    st_wait = 5'b10000
  } standby_state_t;
endpackage
`default_nettype wire

// ### hdl/wake_sync.sv
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree
module wake_sync #(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // Shift chain and agreement filter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sync_out <= '0;
    end else if (ce) begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= (s2 & s3) | (sync_out & (s2 | s3));
    end
  end
endmodule
`default_nettype wire

// ### hdl/standby_mode_controller.sv
`include "standby_defs.svh"
`default_nettype none
// Functional notes
// - Port latches hold their value during HALT
// - Watchdog runs in standby only if enabled
// - Unmasked request ends HALT; vector or continue
// - HALT wake wait 28 or 20 clocks
// - Reset ends HALT, restarts at vector
// - Auto-stopped peripherals halted on HALT entry
// - STOP entered only by STOP instruction
// - Pending unmasked request cancels STOP immediately; code still runs the clock hold, then the wake wait
// - STOP gates CPU clock, main oscillators
// - Slow oscillator run condition in STOP
// - Port latches hold their value during STOP
// - Interval timer, SELECTABLE_POWER_ON_RESET, interrupts stay alive in STOP
// - I2C address match wakes from STOP
// - STOP ends on request, vector or continue after stabilisation
// - STOP wake holds clock, then 11/3 clocks
// - Reset ends STOP, restarts at vector
module standby_mode_controller
  import standby_pkg::*;
#(
  parameter int NIRQ = 16,
  parameter int HOLD_CYC = `STOP_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire logic [NIRQ-1:0] irq_pin,
  input wire logic i2c_addr_match,
  output logic cpu_clk_en,
  output logic cpu_resume,
  output logic cpu_vector,
  output logic fast_osc_en,
  output logic crystal_en,
  output logic ext_clk_en,
  output logic slow_osc_en,
  output logic watchdog_run,
  output logic auto_periph_run,
  output logic interval_timer_run,
  output logic selectable_por_run,
  output logic ext_irq_run,
  output logic comparator_run,
  output logic [31:0] port_latch
);
  localparam logic [5:0] HALT_V = 6'(`HALT_WAIT_VEC);
  localparam logic [5:0] HALT_N = 6'(`HALT_WAIT_NOVEC);
  localparam logic [5:0] STOP_V = 6'(`STOP_WAIT_VEC);
  localparam logic [5:0] STOP_N = 6'(`STOP_WAIT_NOVEC);

  standby_state_t state;
  standby_state_t next_state;
  logic [31:0] ctrl;
  logic [31:0] port_next;
  logic [NIRQ-1:0] irq_mask;
  logic [NIRQ-1:0] irq_req;
  logic [NIRQ-1:0] irq_sync;
  logic [NIRQ-1:0] irq_prev;
  logic [15:0] hold_cnt;
  logic [5:0] wait_cnt;
  logic vec_latched;

  wake_sync #(.WIDTH(NIRQ)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .async_in(irq_pin),
    .sync_out(irq_sync)
  );

  // Bus decode
  wire wr_en = psel && penable && pwrite;
  wire rd_hit = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS) || (paddr == `OFS_PORT_OUT)
                || (paddr == `OFS_IRQ_MASK) || (paddr == `OFS_IRQ_REQ);
  wire wr_ctrl = wr_en && (paddr == `OFS_CTRL);
  wire wr_port = wr_en && (paddr == `OFS_PORT_OUT);
  wire wr_mask = wr_en && (paddr == `OFS_IRQ_MASK);
  wire wr_req = wr_en && (paddr == `OFS_IRQ_REQ);
  wire [NIRQ-1:0] irq_rise = irq_sync & ~irq_prev;
  wire [NIRQ-1:0] sw_clr = wr_req ? pwdata[NIRQ-1:0] : '0;
  wire [NIRQ-1:0] wake_src = irq_req | irq_rise |
                             {{(NIRQ-1){1'b0}}, i2c_addr_match && state == st_stop};
  // Release ignores the acknowledge enable
  wire release_req = |(wake_src & ~irq_mask);
  wire ie = ctrl[`CTRL_IE];
  wire wd_stby = ctrl[`CTRL_WD_STBY];
  wire wd_en = ctrl[`CTRL_WD_ENABLE];
  wire it_sel = ctrl[`CTRL_IT_CLKSEL];
  wire in_standby = (state == st_halt) || (state == st_stop);
  wire stop_like = (state == st_stop) || (state == st_hold);

  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_hit;

  // Read mux
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL: prdata = ctrl;
      `OFS_STATUS: prdata = {26'h000_0000, vec_latched, state};
      `OFS_PORT_OUT: prdata = port_latch;
      `OFS_IRQ_MASK: prdata = 32'(irq_mask);
      `OFS_IRQ_REQ: prdata = 32'(irq_req);
      default: prdata = 32'h0000_0000;
    endcase
  end

  // Port writes blocked in HALT, STOP and the clock hold, but not during the wake wait
  assign port_next = (wr_port && !in_standby && state != st_hold) ? pwdata : port_latch;

  // State machine
  always_comb begin
    next_state = state;
    case (state)
      st_run: begin
        if (stop_exec) begin
          next_state = release_req ? st_hold : st_stop;
        end else if (halt_exec) begin
          next_state = release_req ? st_wait : st_halt;
        end
      end
      st_halt: if (release_req) next_state = st_wait;
      st_stop: if (release_req) next_state = st_hold;
      st_hold: if (hold_cnt == 16'(HOLD_CYC - 1)) next_state = st_wait;
      st_wait: if (wait_cnt == 6'h01) next_state = st_run;
      default: next_state = st_run;
    endcase
  end

  // Reset returns everything to run at the vector
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= st_run;
      ctrl <= `CTRL_RESET;
      port_latch <= `PORT_RESET;
      irq_mask <= NIRQ'(`MASK_RESET);
      irq_req <= '0;
      irq_prev <= '0;
    end else if (ce) begin
      state <= next_state;
      if (wr_ctrl) ctrl <= pwdata;
      port_latch <= port_next;
      if (wr_mask) irq_mask <= pwdata[NIRQ-1:0];
      irq_req <= (irq_req & ~sw_clr) | irq_rise;
      irq_prev <= irq_sync;
    end
  end

  // Wake timing counters
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt <= 16'h0000;
      wait_cnt <= 6'h00;
      vec_latched <= 1'b0;
    end else if (ce) begin
      hold_cnt <= (state == st_hold) ? hold_cnt + 16'h0001 : 16'h0000;
      if (next_state == st_wait && state != st_wait) begin
        vec_latched <= ie;
        wait_cnt <= stop_like ? (ie ? STOP_V : STOP_N) : (ie ? HALT_V : HALT_N);
      end else if (state == st_wait) begin
        wait_cnt <= wait_cnt - 6'h01;
      end
    end
  end

  // Resume pulse with vector select
  assign cpu_resume = (state == st_wait) && (wait_cnt == 6'h01);
  assign cpu_vector = vec_latched;
  assign cpu_clk_en = (state == st_run);
  assign fast_osc_en = !stop_like;
  assign crystal_en = !stop_like;
  assign ext_clk_en = !stop_like;
  assign slow_osc_en = !stop_like || it_sel || (wd_en && wd_stby);
  assign watchdog_run = wd_en && (!in_standby || wd_stby);
  assign auto_periph_run = !in_standby;
  // Always-on units; software owns the others in STOP
  assign interval_timer_run = 1'b1;
  assign selectable_por_run = 1'b1;
  assign ext_irq_run = 1'b1;
  assign comparator_run = !(state == st_stop) || !ctrl[`CTRL_CMP_FILTER];

  a_stop_entry: assert property (@(posedge mclk) disable iff (!nrst)
    ce && $rose(state == st_stop) |-> $past(stop_exec))
    else $error("STOP without instruction");
  a_stop_clocks: assert property (@(posedge mclk) disable iff (!nrst)
    state == st_stop |-> !fast_osc_en && !crystal_en && !cpu_clk_en)
    else $error("clocks running in STOP");
  a_port_hold: assert property (@(posedge mclk) disable iff (!nrst)
    ce && in_standby && $past(in_standby) |-> $stable(port_latch))
    else $error("port changed in standby");
  a_halt_wait: assert property (@(posedge mclk) disable iff (!nrst)
    ce && $past(state) == st_halt && state == st_wait && ie |-> wait_cnt == 6'd28)
    else $error("bad HALT wait");
  a_slow_osc: assert property (@(posedge mclk) disable iff (!nrst)
    state == st_stop && !it_sel && !wd_en |-> !slow_osc_en)
    else $error("slow osc in STOP");
  a_wd_standby: assert property (@(posedge mclk) disable iff (!nrst)
    in_standby && !wd_stby |-> !watchdog_run)
    else $error("watchdog ran");
  a_stop_cancel: assert property (@(posedge mclk) disable iff (!nrst)
    ce && state == st_run && stop_exec && release_req |=> state == st_hold)
    else $error("STOP not cancelled");
  a_halt_release: assert property (@(posedge mclk) disable iff (!nrst)
    ce && state == st_halt && release_req |=> state == st_wait)
    else $error("HALT not released");
  a_periph_stop: assert property (@(posedge mclk) disable iff (!nrst)
    in_standby |-> !auto_periph_run)
    else $error("peripheral ran");
endmodule
`default_nettype wire

// ### verification/cpu_irq_model.sv
`default_nettype none
// CPU core and interrupt controller as seen from the standby block
module cpu_irq_model (
  input wire logic mclk,
  input wire logic cpu_clk_en,
  output logic halt_exec,
  output logic stop_exec,
  output logic [15:0] irq_pin,
  output logic i2c_addr_match
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    halt_exec = 1'b0;
    stop_exec = 1'b0;
    irq_pin = 16'h0000;
    i2c_addr_match = 1'b0;
  end
  // Standby instruction, only issued while the CPU is clocked
  // Timers, serial and converter are taken as quiesced by software first
  task automatic exec(input logic stop);
    @(posedge mclk iff cpu_clk_en === 1'b1);
    halt_exec <= !stop;
    stop_exec <= stop;
    @(posedge mclk);
    halt_exec <= 1'b0;
    stop_exec <= 1'b0;
  endtask
  // Interrupt line level
  task automatic line(input int b, input logic v);
    irq_pin[b] <= v;
  endtask
  // Own slave address seen on the serial bus
  task automatic wake(input logic v);
    i2c_addr_match <= v;
  endtask
endmodule
`default_nettype wire

// ### verification/standby_mode_controller_test.sv
`include "standby_defs.svh"
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module standby_mode_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 8;
  logic mclk = 1'b0, nrst = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, port_latch;
  logic pready, pslverr, halt_exec, stop_exec, i2c_addr_match, cpu_clk_en, cpu_resume, cpu_vector;
  logic fast_osc_en, crystal_en, ext_clk_en, slow_osc_en, watchdog_run, auto_periph_run;
  logic interval_timer_run, selectable_por_run, ext_irq_run, comparator_run;
  logic [15:0] irq_pin;
  int fail_count = 0, tests_run = 0;
  standby_mode_controller #(.NIRQ(16), .HOLD_CYC(HOLD)) dut (.*);
  cpu_irq_model m (.*);
  always #25 mclk = ~mclk;
  // APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CHK("prdata", x, r)
    `CHK("pslverr", xe, e)
  endtask
  // Counts cycles until the resume pulse, sampled mid-cycle
  task automatic resume(input int lo, input logic v);
    int n;
    n = 0;
    @(negedge mclk);
    while (cpu_resume !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    `CHK("wait span", 1'b1, n >= lo && n <= lo + 6)
    `CHK("cpu_vector", v, cpu_vector)
    // Look at the clock gate mid-cycle, once the run state has settled
    @(posedge mclk);
    @(negedge mclk);
    `CHK("cpu_clk_en after wake", 1'b1, cpu_clk_en)
    @(posedge mclk);
  endtask
  // Writes made while the clock enable is low must not land
  task automatic test_freeze;
    ce <= 1'b0;
    wr(`OFS_CTRL, 32'h0000_1011);
    ce <= 1'b1;
    rd(`OFS_CTRL, `CTRL_RESET, 1'b0);
    $display("test_freeze done");
  endtask
  task automatic test_reset;
    rd(`OFS_CTRL, `CTRL_RESET, 1'b0);
    rd(`OFS_IRQ_MASK, `MASK_RESET, 1'b0);
    rd(`OFS_STATUS, 32'h0000_0001, 1'b0);
    rd(12'h014, 32'h0000_0000, 1'b1);
    $display("test_reset done");
  endtask
  task automatic test_halt(input logic ie);
    wr(`OFS_PORT_OUT, 32'h0000_5a5a);
    wr(`OFS_IRQ_MASK, 32'h0000_fffe);
    wr(`OFS_CTRL, 32'h0000_0011 | (32'(ie) << `CTRL_IE));
    m.exec(1'b0);
    wr(`OFS_PORT_OUT, 32'h0000_0000);
    `CHK("cpu_clk_en", 1'b0, cpu_clk_en)
    `CHK("auto_periph_run", 1'b0, auto_periph_run)
    `CHK("watchdog_run", 1'b1, watchdog_run)
    `CHK("port_latch", 32'h0000_5a5a, port_latch)
    m.line(0, 1'b1);
    resume(ie ? `HALT_WAIT_VEC : `HALT_WAIT_NOVEC, ie);
    `CHK("cpu_clk_en", 1'b1, cpu_clk_en)
    m.line(0, 1'b0);
    wr(`OFS_IRQ_REQ, 32'h0000_ffff);
    $display("test_halt done");
  endtask
  task automatic test_stop(input logic [31:0] c, input logic slow);
    wr(`OFS_CTRL, c);
    wr(`OFS_PORT_OUT, 32'h0000_0c3c);
    m.exec(1'b1);
    wr(`OFS_PORT_OUT, 32'h0000_0000);
    `CHK("clocks", 4'b0000, {cpu_clk_en, fast_osc_en, crystal_en, ext_clk_en})
    `CHK("slow_osc_en", slow, slow_osc_en)
    `CHK("watchdog_run", c[0], watchdog_run)
    `CHK("alive", 3'b111, {interval_timer_run, selectable_por_run, ext_irq_run})
    `CHK("comparator_run", !c[16], comparator_run)
    `CHK("port_latch", 32'h0000_0c3c, port_latch)
    m.wake(1'b1);
    resume(HOLD + `STOP_WAIT_NOVEC, 1'b0);
    m.wake(1'b0);
    $display("test_stop done");
  endtask
  task automatic test_pending;
    wr(`OFS_CTRL, 32'h0000_1000);
    m.line(3, 1'b1);
    wr(`OFS_IRQ_MASK, 32'h0000_fff7);
    // Let the request pass the synchroniser so it is pending at the instruction
    repeat (4) @(posedge mclk);
    m.exec(1'b1);
    resume(HOLD + `STOP_WAIT_VEC - 1, 1'b1);
    m.line(3, 1'b0);
    wr(`OFS_IRQ_REQ, 32'h0000_ffff);
    $display("test_pending done");
  endtask
  task automatic test_reset_exit(input logic stop);
    wr(`OFS_PORT_OUT, 32'h0000_00ff);
    m.exec(stop);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    `CHK("cpu_clk_en", 1'b1, cpu_clk_en)
    `CHK("port_latch", `PORT_RESET, port_latch)
    rd(`OFS_STATUS, 32'h0000_0001, 1'b0);
    $display("test_reset_exit done");
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    test_reset();
    test_freeze();
    test_halt(1'b1);
    test_halt(1'b0);
    test_stop(32'h0000_0000, 1'b0);
    test_stop(32'h0000_0100, 1'b1);
    test_stop(32'h0000_0011, 1'b1);
    test_stop(32'h0001_0010, 1'b0);
    test_pending();
    test_reset_exit(1'b0);
    test_reset_exit(1'b1);
    finish_test();
  end
  // Watchdog against a hang
  initial begin
    #(50 * 20000);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
